// File: design/nel_pkg.sv
package nel_pkg;

  // ----------------------------------------------------------------
  // Bus shape
  // ----------------------------------------------------------------
  localparam int NEL_ADDR_W = 8;
  localparam int NEL_DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] NEL_OFS_CTRL     = 8'h00;
  localparam logic [7:0] NEL_OFS_STATUS   = 8'h04;
  localparam logic [7:0] NEL_OFS_R512_S7  = 8'h1C;
  localparam logic [7:0] NEL_OFS_R256_S0  = 8'h20;
  localparam logic [7:0] NEL_OFS_STRIDE   = 8'h04;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int NEL_BIT_LSB      = 0;
  localparam int NEL_WORD_LSB     = 3;
  localparam int NEL_CODE_LSB     = 12;
  localparam int NEL_CODE256_W    = 11;
  localparam int NEL_CODE512_W    = 12;
  localparam int NEL_CTRL_MODE256 = 0;
  localparam int NEL_CTRL_PAGE    = 1;
  localparam int NEL_CTRL_CLEAR   = 8;
  localparam int NEL_STAT_MULTI   = 8;
  localparam int NEL_STAT_512     = 7;

  // ----------------------------------------------------------------
  // Reset values and sector geometry
  // ----------------------------------------------------------------
  localparam logic [31:0] NEL_CTRL_RESET   = 32'h0000_0005;
  localparam logic [12:0] NEL_SECT_256     = 13'h0100;
  localparam logic [12:0] NEL_SECT_512     = 13'h0200;
  localparam logic [12:0] NEL_PAGE_B_512   = 13'h0200;
  localparam logic [12:0] NEL_PAGE_B_2048  = 13'h0800;
  localparam logic [12:0] NEL_PAGE_B_4096  = 13'h1000;
  localparam int          NEL_NUM_256      = 5;
  localparam int          NEL_SECTOR_512   = 7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {NEL_ERR_NONE, NEL_ERR_SINGLE, NEL_ERR_MULTI} nel_err_t;
  typedef enum logic [1:0] {NEL_PAGE_512, NEL_PAGE_2048, NEL_PAGE_4096} nel_page_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  sector;
    nel_err_t    err;
    logic [2:0]  bit_loc;
    logic [11:0] byte_addr;
    logic [11:0] check_code;
  } nel_result_t;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [NEL_ADDR_W-1:0] addr;
    logic [NEL_DATA_W-1:0] wdata;
  } nel_bus_req_t;

  typedef struct packed {
    logic        single;
    logic        multi;
    logic [2:0]  faulty_bit_location;
    logic [8:0]  faulty_word_location;
    logic [11:0] sector_check_code;
  } nel_slot_t;

endpackage

// File: design/nel_sector_slot.sv
`timescale 1ns/100ps
`default_nettype none
module nel_sector_slot import nel_pkg::*; #(
  parameter bit IS_256 = 1'b1,
  parameter int SECTOR = 0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire nel_result_t  result,
  input  wire logic         mode_256,
  input  wire logic [12:0]  page_bytes,
  input  wire logic         clear,
  output logic [31:0]       word,
  output logic              single,
  output logic              multi
);

  // ----------------------------------------------------------------
  // Sector window
  // ----------------------------------------------------------------
  localparam logic [12:0] START = 13'(SECTOR * (IS_256 ? int'(NEL_SECT_256)
                                                       : int'(NEL_SECT_512)));

  initial begin
    if (SECTOR < 0 || SECTOR > 15) begin
      $error("nel_sector_slot: SECTOR out of range");
    end
  end

  nel_slot_t st;
  nel_slot_t next_st;
  logic      hit;

  // ----------------------------------------------------------------
  // Capture of one sector result
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    hit     = result.valid && (result.sector == 4'(SECTOR))
              && (mode_256 == IS_256) && (START < page_bytes);
    if (clear) begin
      next_st = '0;
    end
    if (hit) begin
      next_st.sector_check_code = result.check_code;
      case (result.err)
        NEL_ERR_SINGLE: begin
          next_st.single              = 1'b1;
          next_st.multi               = 1'b0;
          next_st.faulty_bit_location = result.bit_loc;
          next_st.faulty_word_location = IS_256 ? {1'b0, result.byte_addr[7:0]}
                                                : result.byte_addr[8:0];
        end
        NEL_ERR_MULTI: begin
          next_st.single               = 1'b0;
          next_st.multi                = 1'b1;
          next_st.faulty_bit_location  = 3'h0;
          next_st.faulty_word_location = 9'h000;
        end
        default: begin
          next_st.single               = 1'b0;
          next_st.multi                = 1'b0;
          next_st.faulty_bit_location  = 3'h0;
          next_st.faulty_word_location = 9'h000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Register word layout
  // ----------------------------------------------------------------
  always_comb begin
    word = 32'h0000_0000;
    word[NEL_BIT_LSB +: 3] = st.faulty_bit_location;
    if (IS_256) begin
      word[NEL_WORD_LSB +: 8]             = st.faulty_word_location[7:0];
      word[NEL_CODE_LSB +: NEL_CODE256_W] = st.sector_check_code[10:0];
    end else begin
      word[NEL_WORD_LSB +: 9]             = st.faulty_word_location;
      word[NEL_CODE_LSB +: NEL_CODE512_W] = st.sector_check_code;
    end
  end

  assign single = st.single;
  assign multi  = st.multi;

endmodule
`default_nettype wire

// File: design/nel_result_regs.sv
`timescale 1ns/100ps
`default_nettype none
module nel_result_regs import nel_pkg::*; #(
  parameter int NUM_256 = NEL_NUM_256
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire nel_bus_req_t  bus,
  output logic [31:0]        rd_data,
  input  wire nel_result_t   result
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (NUM_256 < 1 || NUM_256 > 7) begin
      $error("nel_result_regs: NUM_256 must be 1 to 7");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        mode_256;
    nel_page_t   page;
    logic        clear;
    logic [31:0] rd_data;
  } nel_top_t;

  nel_top_t    st;
  nel_top_t    next_st;

  logic [31:0] slot_word   [NUM_256];
  logic [NUM_256-1:0] slot_single;
  logic [NUM_256-1:0] slot_multi;
  logic [31:0] word_512;
  logic        single_512;
  logic        multi_512;
  logic [12:0] page_bytes;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // Page size decode
  // ----------------------------------------------------------------
  always_comb begin
    case (st.page)
      NEL_PAGE_512:  begin
        page_bytes = NEL_PAGE_B_512;
      end
      NEL_PAGE_2048: begin
        page_bytes = NEL_PAGE_B_2048;
      end
      default: begin
        page_bytes = NEL_PAGE_B_4096;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sector slots for the 256-byte layout
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_256; g++) begin : g_slot
    nel_sector_slot #(
      .IS_256 (1'b1),
      .SECTOR (g)
    ) u_slot (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .result     (result),
      .mode_256   (st.mode_256),
      .page_bytes (page_bytes),
      .clear      (st.clear),
      .word       (slot_word[g]),
      .single     (slot_single[g]),
      .multi      (slot_multi[g])
    );
  end

  // ----------------------------------------------------------------
  // Last sector of the 512-byte layout
  // ----------------------------------------------------------------
  nel_sector_slot #(
    .IS_256 (1'b0),
    .SECTOR (NEL_SECTOR_512)
  ) u_slot_512 (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .result     (result),
    .mode_256   (st.mode_256),
    .page_bytes (page_bytes),
    .clear      (st.clear),
    .word       (word_512),
    .single     (single_512),
    .multi      (multi_512)
  );

  // ----------------------------------------------------------------
  // Control and status words
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[NEL_CTRL_MODE256]    = st.mode_256;
    ctrl_word[NEL_CTRL_PAGE +: 2]  = st.page;
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[NUM_256-1:0]                   = slot_single;
    status_word[NEL_STAT_MULTI +: NUM_256]     = slot_multi;
    status_word[NEL_STAT_512]                  = single_512;
    status_word[NEL_STAT_MULTI + NEL_STAT_512] = multi_512;
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.clear   = 1'b0;
    next_st.rd_data = 32'h0000_0000;
    if (bus.wr && bus.addr == NEL_OFS_CTRL) begin
      next_st.mode_256 = bus.wdata[NEL_CTRL_MODE256];
      next_st.page     = nel_page_t'(bus.wdata[NEL_CTRL_PAGE +: 2]);
      next_st.clear    = bus.wdata[NEL_CTRL_CLEAR];
    end
    if (bus.rd) begin
      if (bus.addr == NEL_OFS_CTRL) begin
        next_st.rd_data = ctrl_word;
      end
      if (bus.addr == NEL_OFS_STATUS) begin
        next_st.rd_data = status_word;
      end
      if (bus.addr == NEL_OFS_R512_S7) begin
        next_st.rd_data = word_512;
      end
      for (int i = 0; i < NUM_256; i++) begin
        if (bus.addr == NEL_OFS_R256_S0 + 8'(i) * NEL_OFS_STRIDE) begin
          next_st.rd_data = slot_word[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st.mode_256 <= NEL_CTRL_RESET[NEL_CTRL_MODE256];
      st.page     <= nel_page_t'(NEL_CTRL_RESET[NEL_CTRL_PAGE +: 2]);
      st.clear    <= 1'b0;
      st.rd_data  <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data = st.rd_data;

endmodule
`default_nettype wire

// File: verification/nel_result_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
module nel_result_regs_sva import nel_pkg::*; #(
  parameter int NUM_256 = NEL_NUM_256
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire nel_bus_req_t  bus,
  input  wire logic [31:0]   rd_data,
  input  wire nel_result_t   result
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic        mode_q;
  logic [1:0]  page_q;
  nel_result_t res_q;
  nel_result_t res_qq;
  logic        acc256;
  logic        acc512;

  always_ff @(posedge clk_sys) begin
    res_q  <= result;
    res_qq <= res_q;
    if (rst) begin
      mode_q <= NEL_CTRL_RESET[NEL_CTRL_MODE256];
      page_q <= NEL_CTRL_RESET[NEL_CTRL_PAGE +: 2];
    end else if (bus.wr && bus.addr == NEL_OFS_CTRL) begin
      mode_q <= bus.wdata[NEL_CTRL_MODE256];
      page_q <= bus.wdata[NEL_CTRL_PAGE +: 2];
    end
  end

  assign acc256 = result.valid && mode_q && (int'(result.sector) < NUM_256)
                  && (result.sector < 4'h2 || page_q != 2'b00);
  assign acc512 = result.valid && !mode_q && result.sector == 4'h7 && page_q[1];

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_rd256(e);
    (acc256 && result.err == e) ##1
    (bus.rd && !result.valid && bus.addr == NEL_OFS_R256_S0 + 8'({res_q.sector, 2'b00}));
  endsequence
  sequence s_rd512;
    (acc512 && result.err == NEL_ERR_SINGLE) ##1
    (bus.rd && !result.valid && bus.addr == NEL_OFS_R512_S7);
  endsequence

  property p_rd_idle;   !bus.rd |=> rd_data == 32'h0000_0000; endproperty
  property p_unmapped;  bus.rd && bus.addr == 8'h10 |=> rd_data == 32'h0000_0000; endproperty
  property p_r256_zero;
    bus.rd && bus.addr >= NEL_OFS_R256_S0 && bus.addr <= 8'h30
    |=> rd_data[31:23] == 9'h000 && !rd_data[11];
  endproperty
  property p_r512_zero; bus.rd && bus.addr == NEL_OFS_R512_S7 |=> rd_data[31:24] == 8'h00;
  endproperty
  property p_bit;  s_rd256(NEL_ERR_SINGLE) |=> rd_data[2:0] == res_qq.bit_loc; endproperty
  property p_word; s_rd256(NEL_ERR_SINGLE) |=> rd_data[10:3] == res_qq.byte_addr[7:0];
  endproperty
  property p_code; s_rd256(NEL_ERR_SINGLE) |=> rd_data[22:12] == res_qq.check_code[10:0];
  endproperty
  property p_multi;
    s_rd256(NEL_ERR_MULTI) |=> rd_data[10:0] == 11'h000
                               && rd_data[22:12] == res_qq.check_code[10:0];
  endproperty
  property p_512;
    s_rd512 |=> rd_data[23:0] == {res_qq.check_code, res_qq.byte_addr[8:0], res_qq.bit_loc};
  endproperty

  a_rd_idle:   assert property (p_rd_idle)   else $error("read data not zero when idle");
  a_unmapped:  assert property (p_unmapped)  else $error("unmapped read not zero");
  a_r256_zero: assert property (p_r256_zero) else $error("reserved bits set");
  a_r512_zero: assert property (p_r512_zero) else $error("upper bits set");
  a_bit:       assert property (p_bit)       else $error("bit location wrong");
  a_word:      assert property (p_word)      else $error("word location wrong");
  a_code:      assert property (p_code)      else $error("check code wrong");
  a_multi:     assert property (p_multi)     else $error("multi result wrong");
  a_512:       assert property (p_512)       else $error("sector seven result wrong");

  c_single: cover property (s_rd256(NEL_ERR_SINGLE));
  c_multi:  cover property (s_rd256(NEL_ERR_MULTI));
  c_512:    cover property (s_rd512);
  c_clear_hit: cover property (bus.wr && bus.addr == NEL_OFS_CTRL && bus.wdata[NEL_CTRL_CLEAR]
                               ##1 acc256);
endmodule

bind nel_result_regs nel_result_regs_sva #(.NUM_256(NUM_256)) nel_result_regs_sva_inst (
  .clk_sys(clk_sys), .rst(rst), .bus(bus), .rd_data(rd_data), .result(result));
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module testbench import nel_pkg::*;;
  localparam int N = 5;
  logic         clk_sys = 1'b0;
  logic         rst     = 1'b1;
  nel_bus_req_t bus     = '0;
  nel_result_t  result  = '0;
  logic [31:0]  rd_data;
  logic [31:0]  exp_q[$];
  logic [31:0]  slot_exp[8] = '{default: '0};
  logic [31:0]  e;
  logic         pend = 1'b0;
  int           failures = 0;
  int           compares = 0;

  always #50 clk_sys = ~clk_sys;

  nel_result_regs #(.NUM_256(N)) nel_result_regs_inst (
    .clk_sys(clk_sys), .rst(rst), .bus(bus), .rd_data(rd_data), .result(result));

  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  always @(posedge clk_sys) pend <= bus.rd;
  always @(negedge clk_sys) begin
    if (pend) begin
      e = exp_q.pop_front();
      `CHK("rd_data", e, rd_data)
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic op(logic r, logic w, logic [7:0] a, logic [31:0] d, nel_result_t res);
    @(posedge clk_sys);
    bus    <= '{wr: w, rd: r, addr: a, wdata: d};
    result <= res;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] x);
    exp_q.push_back(x);
    op(1'b1, 1'b0, a, 32'h0000_0000, '0);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    op(1'b0, 1'b1, a, d, '0);
  endtask
  task automatic hit(logic [3:0] s, nel_err_t er, logic m256, logic take);
    nel_result_t r;
    logic [31:0] x;
    r = '{valid: 1'b1, sector: s, err: er, bit_loc: 3'($urandom),
          byte_addr: 12'($urandom), check_code: 12'($urandom)};
    if (m256) x = {9'h000, r.check_code[10:0], 1'b0, r.byte_addr[7:0], r.bit_loc};
    else x = {8'h00, r.check_code, r.byte_addr[8:0], r.bit_loc};
    if (er != NEL_ERR_SINGLE) x = x & (m256 ? 32'hFFFF_F800 : 32'hFFFF_F000);
    if (take) slot_exp[s[2:0]] = x;
    op(1'b0, 1'b0, 8'h00, 32'h0000_0000, r);
    rd(m256 ? NEL_OFS_R256_S0 + 8'({s, 2'b00}) : NEL_OFS_R512_S7, slot_exp[s[2:0]]);
  endtask

  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(100000 * 100);
    failures++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(24120));
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(NEL_OFS_CTRL, NEL_CTRL_RESET);
    rd(NEL_OFS_STATUS, 32'h0000_0000);
    wr(NEL_OFS_R256_S0, 32'hFFFF_FFFF);
    rd(NEL_OFS_R256_S0, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < N; s++) hit(4'(s), nel_err_t'((k + 2) % 3), 1'b1, 1'b1);
    end
    rd(NEL_OFS_STATUS, 32'h0000_001F);
    hit(4'h3, NEL_ERR_MULTI, 1'b1, 1'b1);
    rd(NEL_OFS_STATUS, 32'h0000_0817);
    hit(4'h5, NEL_ERR_SINGLE, 1'b1, 1'b0);
    wr(NEL_OFS_CTRL, 32'h0000_0001);
    hit(4'h2, NEL_ERR_SINGLE, 1'b1, 1'b0);
    hit(4'h1, NEL_ERR_SINGLE, 1'b1, 1'b1);
    wr(NEL_OFS_CTRL, 32'h0000_0105);
    slot_exp = '{default: '0};
    rd(NEL_OFS_CTRL, 32'h0000_0005);
    rd(NEL_OFS_R256_S0 + 8'h04, 32'h0000_0000);
    wr(NEL_OFS_CTRL, 32'h0000_0004);
    hit(4'h7, NEL_ERR_SINGLE, 1'b0, 1'b1);
    rd(NEL_OFS_STATUS, 32'h0000_0080);
    hit(4'h0, NEL_ERR_SINGLE, 1'b1, 1'b0);
    hit(4'h7, NEL_ERR_MULTI, 1'b0, 1'b1);
    rd(NEL_OFS_STATUS, 32'h0000_8000);
    wr(NEL_OFS_CTRL, 32'h0000_0002);
    hit(4'h7, NEL_ERR_SINGLE, 1'b0, 1'b0);
    wr(NEL_OFS_CTRL, 32'h0000_0107);
    slot_exp = '{default: '0};
    hit(4'h4, NEL_ERR_SINGLE, 1'b1, 1'b1);
    rd(NEL_OFS_CTRL, 32'h0000_0007);
    rd(NEL_OFS_STATUS, 32'h0000_0010);
    for (int s = 0; s < N; s++) rd(NEL_OFS_R256_S0 + 8'(4 * s), slot_exp[s]);
    rd(NEL_OFS_R512_S7, slot_exp[7]);
    op(1'b0, 1'b0, 8'h00, 32'h0000_0000, '0);
    repeat (3) @(posedge clk_sys);
    end_sim();
  end
endmodule
`default_nettype wire
